// ### lsdb_pkg.sv
// Package with register map, field layout and bus types for the bank.
package lsdb_pkg;

   // ************************************************************
   // Register map and field layout.
   // ************************************************************
   localparam int          LSDB_NUM_REGS    = 6;
   localparam int          LSDB_NIB_W       = 4;
   localparam int          LSDB_NUM_COMS    = 4;
   localparam int          LSDB_FIELD_HI_LSB = 4;
   localparam int          LSDB_FIELD_LO_LSB = 0;
   localparam int          LSDB_DATA_W      = 8;
   localparam int          LSDB_ADDR_W      = 8;
   localparam int          LSDB_FIRST_SEG   = 18;
   localparam logic [7:0]  LSDB_OFS_SEGMENT_OUTPUT_18_19 = 8'h00;
   localparam logic [7:0]  LSDB_OFS_SEGMENT_OUTPUT_20_21 = 8'h04;
   localparam logic [7:0]  LSDB_OFS_SEGMENT_OUTPUT_22_23 = 8'h08;
   localparam logic [7:0]  LSDB_OFS_SEGMENT_OUTPUT_24_25 = 8'h0c;
   localparam logic [7:0]  LSDB_OFS_SEGMENT_OUTPUT_26_27 = 8'h10;
   localparam logic [7:0]  LSDB_OFS_SEGMENT_OUTPUT_28_29 = 8'h14;
   localparam logic [7:0]  LSDB_RESET_VAL   = 8'h00;

   // ************************************************************
   // Bus constants.
   // ************************************************************
   localparam logic [1:0]  LSDB_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  LSDB_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } lsdb_wreq_t;

   typedef struct packed {
      logic [LSDB_NIB_W-1:0] seg_hi;
      logic [LSDB_NIB_W-1:0] seg_lo;
   } lsdb_pair_t;

   typedef enum logic [1:0] {
      LSDB_W_IDLE = 2'b00,
      LSDB_W_RESP = 2'b01
   } lsdb_wstate_t;

endpackage

// ### lsdb_seg_drive.sv
// Segment drive selector: picks each segment's bit for the active common.
`timescale 1ns/1ps
module lsdb_seg_drive (
   input  wire logic [lsdb_pkg::LSDB_NUM_REGS*8-1:0] i_patterns,
   input  wire logic [1:0]                           i_com_sel,
   output logic      [lsdb_pkg::LSDB_NUM_REGS*2-1:0] o_seg_on
);
   import lsdb_pkg::*;

   // ************************************************************
   // One bit per common in each nibble, bit 3 for common line 3.
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < LSDB_NUM_REGS * 2; g = g + 1) begin : g_seg
         assign o_seg_on[g] = i_patterns[g*LSDB_NIB_W + i_com_sel];
      end
   endgenerate

endmodule

// ### lsdb_bank.sv
// Segment pattern register bank for segments 18 to 29 on AXI4-Lite.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module lsdb_bank (
   input  wire logic                                 i_sys_clk,
   input  wire logic                                 i_rst,
   input  wire logic [7:0]                           i_awaddr,
   input  wire logic                                 i_awvalid,
   output logic                                      o_awready,
   input  wire logic [31:0]                          i_wdata,
   input  wire logic [3:0]                           i_wstrb,
   input  wire logic                                 i_wvalid,
   output logic                                      o_wready,
   output logic [1:0]                                o_bresp,
   output logic                                      o_bvalid,
   input  wire logic                                 i_bready,
   input  wire logic [7:0]                           i_araddr,
   input  wire logic                                 i_arvalid,
   output logic                                      o_arready,
   output logic [31:0]                               o_rdata,
   output logic [1:0]                                o_rresp,
   output logic                                      o_rvalid,
   input  wire logic                                 i_rready,
   input  wire logic [1:0]                           i_com_sel,
   output logic [lsdb_pkg::LSDB_NUM_REGS*2-1:0]      o_seg_on,
   output logic [lsdb_pkg::LSDB_NUM_REGS*8-1:0]      o_patterns
);
   import lsdb_pkg::*;

   // ************************************************************
   // Address decode.
   // ************************************************************
   function automatic logic [3:0] lsdb_decode(input logic [7:0] a);
      case (a)
         LSDB_OFS_SEGMENT_OUTPUT_18_19: lsdb_decode = 4'h0;
         LSDB_OFS_SEGMENT_OUTPUT_20_21: lsdb_decode = 4'h1;
         LSDB_OFS_SEGMENT_OUTPUT_22_23: lsdb_decode = 4'h2;
         LSDB_OFS_SEGMENT_OUTPUT_24_25: lsdb_decode = 4'h3;
         LSDB_OFS_SEGMENT_OUTPUT_26_27: lsdb_decode = 4'h4;
         LSDB_OFS_SEGMENT_OUTPUT_28_29: lsdb_decode = 4'h5;
         default:           lsdb_decode = 4'hf;
      endcase
   endfunction

   lsdb_pair_t   pair_r [LSDB_NUM_REGS];
   lsdb_wstate_t wstate_r;
   logic         aw_held_r;
   logic         w_held_r;
   lsdb_wreq_t   wreq_r;
   logic         do_write;
   logic [3:0]   widx;
   logic [3:0]   ridx;

   // ************************************************************
   // Write channel: address and data taken in either order.
   // ************************************************************
   assign o_awready = (wstate_r == LSDB_W_IDLE) && !aw_held_r;
   assign o_wready  = (wstate_r == LSDB_W_IDLE) && !w_held_r;
   assign do_write  = (wstate_r == LSDB_W_IDLE)
                      && (aw_held_r || i_awvalid)
                      && (w_held_r || i_wvalid);
   assign widx      = lsdb_decode(aw_held_r ? wreq_r.addr : i_awaddr);

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         aw_held_r <= 1'b0;
         wreq_r.addr <= 8'h00;
      end else if (do_write) begin
         aw_held_r <= 1'b0;
      end else if (i_awvalid && o_awready) begin
         aw_held_r   <= 1'b1;
         wreq_r.addr <= i_awaddr;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         w_held_r    <= 1'b0;
         wreq_r.data <= 32'h0000_0000;
         wreq_r.strb <= 4'h0;
      end else if (do_write) begin
         w_held_r <= 1'b0;
      end else if (i_wvalid && o_wready) begin
         w_held_r    <= 1'b1;
         wreq_r.data <= i_wdata;
         wreq_r.strb <= i_wstrb;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         wstate_r <= LSDB_W_IDLE;
         o_bvalid <= 1'b0;
         o_bresp  <= LSDB_RESP_OKAY;
      end else begin
         case (wstate_r)
            LSDB_W_IDLE: begin
               if (do_write) begin
                  wstate_r <= LSDB_W_RESP;
                  o_bvalid <= 1'b1;
                  o_bresp  <= (widx == 4'hf) ? LSDB_RESP_SLVERR
                                             : LSDB_RESP_OKAY;
               end
            end
            LSDB_W_RESP: begin
               if (i_bready) begin
                  wstate_r <= LSDB_W_IDLE;
                  o_bvalid <= 1'b0;
               end
            end
            default: begin
               wstate_r <= LSDB_W_IDLE;
               o_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // Pattern storage; only byte lane 0 holds state.
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < LSDB_NUM_REGS; g = g + 1) begin : g_reg
         logic [31:0] wd;
         logic        ws;
         assign wd = w_held_r ? wreq_r.data : i_wdata;
         assign ws = w_held_r ? wreq_r.strb[0] : i_wstrb[0];
         always_ff @(posedge i_sys_clk or posedge i_rst) begin
            if (i_rst) begin
               pair_r[g] <= LSDB_RESET_VAL;
            end else if (do_write && widx == 4'(g) && ws) begin
               // Upper nibble is the odd segment, lower the even one.
               pair_r[g].seg_hi <= wd[LSDB_FIELD_HI_LSB +: LSDB_NIB_W];
               pair_r[g].seg_lo <= wd[LSDB_FIELD_LO_LSB +: LSDB_NIB_W];
            end
         end
         assign o_patterns[g*8 +: 8] = pair_r[g];
      end
   endgenerate
   // Register g covers segments 18+2g and 19+2g.

   // ************************************************************
   // Read channel: one-cycle answer, bits 31-8 read zero.
   // ************************************************************
   assign o_arready = !o_rvalid;
   assign ridx      = lsdb_decode(i_araddr);

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rvalid <= 1'b0;
         o_rdata  <= 32'h0000_0000;
         o_rresp  <= LSDB_RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_rvalid <= 1'b1;
         if (ridx == 4'hf) begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= LSDB_RESP_SLVERR;
         end else begin
            o_rdata <= {24'h00_0000, pair_r[ridx[2:0]]};
            o_rresp <= LSDB_RESP_OKAY;
         end
      end else if (i_rready) begin
         o_rvalid <= 1'b0;
      end
   end

   // ************************************************************
   // Segment drive for the active common phase.
   // ************************************************************
   lsdb_seg_drive u_drive (
      .i_patterns (o_patterns),
      .i_com_sel  (i_com_sel),
      .o_seg_on   (o_seg_on)
   );

endmodule

// ### lsdb_bank_monitor.sv
// Checker of bus timing and segment drive for the pattern bank.
`timescale 1ns/1ps
module lsdb_bank_monitor (
   input wire logic        i_sys_clk, i_rst, i_awvalid, o_awready,
   input wire logic        i_wvalid, o_wready, o_bvalid, i_bready,
   input wire logic        i_arvalid, o_arready, o_rvalid, i_rready,
   input wire logic [7:0]  i_awaddr,
   input wire logic [31:0] i_wdata, o_rdata,
   input wire logic [3:0]  i_wstrb,
   input wire logic [1:0]  i_com_sel,
   input wire logic [11:0] o_seg_on,
   input wire logic [47:0] o_patterns
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   sequence wr_take;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   a_write_answer: assert property (wr_take |=> o_bvalid)
      else $error("write response late");
   a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
      else $error("write response dropped");
   a_write_lands: assert property (
      (wr_take ##0 (i_awaddr == 8'h00 && i_wstrb[0]))
      |=> o_patterns[7:0] == $past(i_wdata[7:0]))
      else $error("write did not land");
   a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   a_read_hold: assert property (o_rvalid && !i_rready
      |=> o_rvalid && $stable(o_rdata)) else $error("read data moved");
   a_read_block: assert property (o_rvalid && i_rready
      |=> !o_rvalid && o_arready) else $error("read answer not retired");
   a_upper_zero: assert property (
      o_rvalid |-> o_rdata[31:8] == 24'h00_0000) else $error("upper bits");
   for (genvar g = 0; g < 6; g++) begin : g_pair
      a_seg_low: assert property (
         o_seg_on[2*g] == o_patterns[8*g+i_com_sel]) else $error("low seg");
      a_seg_high: assert property (
         o_seg_on[2*g+1] == o_patterns[8*g+4+i_com_sel])
         else $error("high seg");
   end
endmodule

// ### lsdb_testbench.sv
// Self-checking bench for the segment pattern register bank.
`timescale 1ns/1ps
module testbench;
   import lsdb_pkg::*;
   logic        i_sys_clk = 0, i_rst = 1, i_awvalid = 0, i_wvalid = 0;
   logic        i_bready = 0, i_arvalid = 0, i_rready = 0;
   logic [7:0]  i_awaddr = 0, i_araddr = 0;
   logic [31:0] i_wdata = 0, o_rdata;
   logic [3:0]  i_wstrb = 0;
   logic [1:0]  i_com_sel = 0, o_bresp, o_rresp;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [11:0] o_seg_on;
   logic [47:0] o_patterns;
   int          err_count = 0, n_checks = 0;
   lsdb_bank lsdb_bank_inst (.i_sys_clk, .i_rst, .i_awaddr, .i_awvalid,
      .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp,
      .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
      .o_rresp, .o_rvalid, .i_rready, .i_com_sel, .o_seg_on, .o_patterns);
   initial forever #25 i_sys_clk = ~i_sys_clk;
   task automatic close_out;
      $display("errors %0d checks %0d", err_count, n_checks);
      if (err_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hung;
      err_count++;
      $display("BAD %0t no answer", $time);
      close_out;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      logic ta, tw, tb;
      int   n = 0;
      i_awaddr <= a;
      i_wdata <= d;
      i_wstrb <= s;
      i_awvalid <= 1'h1;
      i_wvalid <= 1'h1;
      i_bready <= 1'h1;
      do begin
         @(negedge i_sys_clk);
         ta = i_awvalid && o_awready;
         tw = i_wvalid && o_wready;
         tb = o_bvalid;
         if (tb) chk({30'h0, o_bresp}, {30'h0, er});
         @(posedge i_sys_clk);
         if (ta) i_awvalid <= 1'h0;
         if (tw) i_wvalid <= 1'h0;
         if (++n > 20) hung;
      end while (!tb);
      i_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      logic ta, tr;
      int   n = 0;
      i_araddr <= a;
      i_arvalid <= 1'h1;
      i_rready <= 1'h1;
      do begin
         @(negedge i_sys_clk);
         ta = i_arvalid && o_arready;
         tr = o_rvalid;
         if (tr) chk(o_rdata, ed);
         if (tr) chk({30'h0, o_rresp}, {30'h0, er});
         @(posedge i_sys_clk);
         if (ta) i_arvalid <= 1'h0;
         if (++n > 20) hung;
      end while (!tr);
      i_rready <= 1'h0;
      @(posedge i_sys_clk);
   endtask
   task automatic t_fields;
      logic [7:0] v;
      for (int g = 0; g < 6; g++) begin
         v = 8'h12 + 8'(g * 17);
         rd(8'(g * 4), 32'h0, LSDB_RESP_OKAY);
         wr(8'(g * 4), {24'hff_ffff, v}, 4'hf, LSDB_RESP_OKAY);
         rd(8'(g * 4), {24'h0, v}, LSDB_RESP_OKAY);
         chk({24'h0, o_patterns[8*g +: 8]}, {24'h0, v});
      end
   endtask
   task automatic t_refuse;
      wr(8'h00, 32'h0000_00ff, 4'he, LSDB_RESP_OKAY);
      rd(8'h00, 32'h0000_0012, LSDB_RESP_OKAY);
      wr(8'h18, 32'h0000_00ff, 4'hf, LSDB_RESP_SLVERR);
      rd(8'h18, 32'h0, LSDB_RESP_SLVERR);
   endtask
   task automatic t_commons;
      logic [11:0] e;
      logic [7:0]  v;
      for (int c = 0; c < 4; c++) begin
         i_com_sel <= 2'(c);
         @(negedge i_sys_clk);
         for (int g = 0; g < 6; g++) begin
            v = 8'h12 + 8'(g * 17);
            e[2*g] = v[c];
            e[2*g+1] = v[4+c];
         end
         chk({20'h0, o_seg_on}, {20'h0, e});
         @(posedge i_sys_clk);
      end
   endtask
   task automatic t_stall;
      int n = 0;
      i_awaddr <= LSDB_OFS_SEGMENT_OUTPUT_20_21;
      i_wdata <= 32'h0000_00a5;
      i_wstrb <= 4'h1;
      i_awvalid <= 1'h1;
      i_wvalid <= 1'h1;
      do begin
         @(negedge i_sys_clk);
         n++;
      end while (!(o_awready && o_wready) && n < 20);
      if (n >= 20) hung;
      @(posedge i_sys_clk);
      i_awvalid <= 1'h0;
      i_wvalid <= 1'h0;
      repeat (3) @(negedge i_sys_clk);
      chk({31'h0, o_bvalid}, 32'h0000_0001);
      chk({30'h0, o_bresp}, {30'h0, LSDB_RESP_OKAY});
      @(posedge i_sys_clk);
      i_bready <= 1'h1;
      @(posedge i_sys_clk);
      i_bready <= 1'h0;
      i_araddr <= LSDB_OFS_SEGMENT_OUTPUT_20_21;
      i_arvalid <= 1'h1;
      n = 0;
      do begin
         @(negedge i_sys_clk);
         n++;
      end while (!o_arready && n < 20);
      if (n >= 20) hung;
      @(posedge i_sys_clk);
      i_arvalid <= 1'h0;
      repeat (3) @(negedge i_sys_clk);
      chk({31'h0, o_rvalid}, 32'h0000_0001);
      chk(o_rdata, 32'h0000_00a5);
      chk({24'h0, o_patterns[15:8]}, 32'h0000_00a5);
      @(posedge i_sys_clk);
      i_rready <= 1'h1;
      @(posedge i_sys_clk);
      i_rready <= 1'h0;
      @(negedge i_sys_clk);
      chk({31'h0, o_rvalid}, 32'h0000_0000);
      @(posedge i_sys_clk);
   endtask
   initial begin
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'h0;
      t_fields;
      t_refuse;
      t_commons;
      t_stall;
      close_out;
   end
endmodule
bind lsdb_bank lsdb_bank_monitor lsdb_bank_monitor_inst (.i_sys_clk, .i_rst,
   .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_bready,
   .i_arvalid, .o_arready, .o_rvalid, .i_rready, .i_awaddr, .i_wdata,
   .o_rdata, .i_wstrb, .i_com_sel, .o_seg_on, .o_patterns);
